// ---- logic/ssbp_pkg.sv ----
`default_nettype none
package ssbp_pkg;

   // ----------------------------------------------------------------
   // Register indices; byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [9:0] SSBP_CTRL_IDX = 10'h0a6;
   localparam logic [9:0] SSBP_STAT_IDX = 10'h0a7;
   localparam logic [9:0] SSBP_LAST_IDX = 10'h0a8;
   localparam logic [9:0] SSBP_IRQ_STAT_IDX = 10'h0a9;
   localparam logic [9:0] SSBP_IRQ_EN_IDX = 10'h0aa;
   localparam logic [9:0] SSBP_IRQ_CLR_IDX = 10'h0ab;
   localparam logic [9:0] SSBP_BUF_IDX = 10'h080;

   // ----------------------------------------------------------------
   // Field layout and reset values.
   // ----------------------------------------------------------------
   localparam int SSBP_CKS_LSB = 0;
   localparam int SSBP_GAP_LSB = 3;
   localparam int SSBP_STF_BIT = 0;
   localparam int SSBP_ABT_BIT = 1;
   localparam int SSBP_WT_BIT = 2;
   localparam int SSBP_OVERRUN_FLAG_BIT = 3;
   localparam int SSBP_SOL_BIT = 4;
   localparam logic [2:0] SSBP_RSVD_ONES = 3'h7;
   localparam logic [2:0] SSBP_CKS_EXT = 3'h7;
   localparam logic [2:0] SSBP_CKS_RESET = 3'h0;
   localparam logic [1:0] SSBP_GAP_RESET = 2'h0;
   localparam logic [4:0] SSBP_LAST_RESET = 5'h1f;
   localparam int SSBP_IRQ_DONE = 0;
   localparam int SSBP_IRQ_ABT = 1;
   localparam int SSBP_IRQ_WT = 2;
   localparam int SSBP_IRQ_OVERRUN_FLAG = 3;
   localparam int SSBP_IRQ_W = 4;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_WAIT_CS = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_GAP = 4'b1000
   } ssbp_state_e;

   // Half a serial clock period in pclk cycles for each internal code.
   function automatic logic [7:0] ssbp_half_period(input logic [2:0] cks);
      case (cks)
         3'h0: ssbp_half_period = 8'h80;
         3'h1: ssbp_half_period = 8'h20;
         3'h2: ssbp_half_period = 8'h10;
         3'h3: ssbp_half_period = 8'h08;
         3'h4: ssbp_half_period = 8'h04;
         3'h5: ssbp_half_period = 8'h02;
         3'h6: ssbp_half_period = 8'h01;
         default: ssbp_half_period = 8'h01;
      endcase
   endfunction

   // Idle serial clocks inserted between bytes.
   function automatic logic [5:0] ssbp_gap_cycles(input logic [1:0] gap);
      case (gap)
         2'h0: ssbp_gap_cycles = 6'h00;
         2'h1: ssbp_gap_cycles = 6'h08;
         2'h2: ssbp_gap_cycles = 6'h18;
         2'h3: ssbp_gap_cycles = 6'h38;
         default: ssbp_gap_cycles = 6'h00;
      endcase
   endfunction

endpackage
`default_nettype wire

// ---- logic/ssbp_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbp_prescaler
   import ssbp_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] cks,
   input wire logic run,
   output logic sck_level,
   output logic fall_tick,
   output logic rise_tick
);

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] half_m1;

   // ----------------------------------------------------------------
   // Elaboration check.
   // ----------------------------------------------------------------
   if (CNT_W < 8)
   begin : g_bad_width
      $error("Counter too narrow for the slowest division.");
   end

   assign half_m1 = CNT_W'(ssbp_half_period(cks) - 8'h01);

   // The clock idles high, so the first edge of a byte is a falling one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt <= '0;
         sck_level <= 1'b1;
      end
      else if (!run)
      begin
         cnt <= half_m1;
         sck_level <= 1'b1;
      end
      else if (cnt == '0)
      begin
         cnt <= half_m1;
         sck_level <= ~sck_level;
      end
      else
      begin
         cnt <= cnt - CNT_W'(1);
      end
   end

   assign fall_tick = run && (cnt == '0) && sck_level;
   assign rise_tick = run && (cnt == '0) && !sck_level;

endmodule
`default_nettype wire

// ---- logic/ssbp_top.sv ----
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ssbp_top
   import ssbp_pkg::*;
#(
   parameter int BUF_DEPTH = 32
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe_n,
   output logic so_out,
   input wire logic si_in,
   input wire logic cs_n_in,
   output logic irq
);

   if (BUF_DEPTH != 32)
   begin : g_bad_depth
      $error("Buffer depth must be 32 to match the index decode.");
   end

   ssbp_state_e state;
   logic [7:0] buffer [BUF_DEPTH];
   logic [2:0] cks, bitn, armed, clr_hit;
   logic [1:0] gap;
   logic [4:0] last, idx;
   logic [5:0] gap_cnt;
   logic [7:0] rx;
   logic overrun_flag, wt, abort_flag, done_seen, abort_ev;
   logic [SSBP_IRQ_W-1:0] irq_stat, irq_en;
   logic sck_s1, sck_s2, sck_s3, cs_s1, cs_s2, cs_s3, si_s1, si_s2;
   logic ext, int_level, int_fall, int_rise, fall_ev, rise_ev, cs_rise;
   logic setup, access, wr, rd, mapped, busy, is_buf;
   logic [9:0] word;
   logic byte_done, last_byte, start_wr, stat_wr, stat_rd, buf_wait, ovr_ev;

   // ----------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {sck_s1, sck_s2, sck_s3} <= 3'h7;
         {cs_s1, cs_s2, cs_s3} <= 3'h7;
         {si_s1, si_s2} <= 2'h0;
      end
      else
      begin
         {sck_s1, sck_s2, sck_s3} <= {sck_in, sck_s1, sck_s2};
         {cs_s1, cs_s2, cs_s3} <= {cs_n_in, cs_s1, cs_s2};
         {si_s1, si_s2} <= {si_in, si_s1};
      end
   end

   // ----------------------------------------------------------------
   // Serial clock source.
   // ----------------------------------------------------------------
   assign ext = (cks == SSBP_CKS_EXT);
   assign busy = (state != ST_IDLE);

   ssbp_prescaler #(.CNT_W(8)) u_presc
   (
      .pclk(pclk),
      .presetn(presetn),
      .cks(cks),
      .run(!ext && (state == ST_SHIFT || state == ST_GAP)),
      .sck_level(int_level),
      .fall_tick(int_fall),
      .rise_tick(int_rise)
   );

   assign fall_ev = ext ? (sck_s3 & ~sck_s2) : int_fall;
   assign rise_ev = ext ? (~sck_s3 & sck_s2) : int_rise;
   assign sck_out = (state == ST_SHIFT && !ext) ? int_level : 1'b1;
   assign sck_oe_n = ext;
   assign cs_rise = cs_s2 & ~cs_s3;

   // ----------------------------------------------------------------
   // Bus decode.
   // ----------------------------------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign word = paddr[11:2];
   assign is_buf = (word[9:5] == SSBP_BUF_IDX[9:5]);
   assign mapped = is_buf || word == SSBP_CTRL_IDX || word == SSBP_STAT_IDX || word == SSBP_LAST_IDX
                   || word == SSBP_IRQ_STAT_IDX || word == SSBP_IRQ_EN_IDX || word == SSBP_IRQ_CLR_IDX;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign stat_wr = wr && word == SSBP_STAT_IDX;
   assign stat_rd = rd && word == SSBP_STAT_IDX;
   assign start_wr = stat_wr && pwdata[SSBP_STF_BIT] && !busy;
   assign buf_wait = access && is_buf && busy;
   assign byte_done = (state == ST_SHIFT) && rise_ev && (bitn == 3'h7);
   assign last_byte = (idx == last);
   assign ovr_ev = ext && !busy && done_seen && fall_ev;
   assign abort_ev = (state == ST_SHIFT || state == ST_GAP) && cs_rise;
   assign clr_hit = {3{stat_wr}} & armed & ~pwdata[SSBP_ABT_BIT +: 3];

   // Read data is latched in the setup cycle so it comes from a flip-flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
      end
      else if (setup && !pwrite)
      begin
         prdata <= '0;
         if (is_buf && !busy)
            prdata[7:0] <= buffer[word[4:0]];
         else if (word == SSBP_CTRL_IDX)
            prdata[7:0] <= {SSBP_RSVD_ONES, gap, cks};
         else if (word == SSBP_STAT_IDX)
            prdata[7:0] <= {SSBP_RSVD_ONES, so_out, overrun_flag, wt, abort_flag, busy};
         else if (word == SSBP_LAST_IDX)
            prdata[4:0] <= last;
         else if (word == SSBP_IRQ_STAT_IDX)
            prdata[SSBP_IRQ_W-1:0] <= irq_stat;
         else if (word == SSBP_IRQ_EN_IDX)
            prdata[SSBP_IRQ_W-1:0] <= irq_en;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cks <= SSBP_CKS_RESET;
         gap <= SSBP_GAP_RESET;
         last <= SSBP_LAST_RESET;
         irq_en <= '0;
      end
      else if (wr)
      begin
         if (word == SSBP_CTRL_IDX)
         begin
            cks <= pwdata[SSBP_CKS_LSB +: 3];
            gap <= pwdata[SSBP_GAP_LSB +: 2];
         end
         if (word == SSBP_LAST_IDX)
            last <= pwdata[4:0];
         if (word == SSBP_IRQ_EN_IDX)
            irq_en <= pwdata[SSBP_IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Transfer sequencer.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         idx <= '0;
         bitn <= '0;
         gap_cnt <= '0;
         rx <= '0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (start_wr)
               begin
                  idx <= '0;
                  bitn <= '0;
                  state <= cs_s2 ? ST_WAIT_CS : ST_SHIFT;
               end
            end
            ST_WAIT_CS:
            begin
               if (!cs_s2)
                  state <= ST_SHIFT;
            end
            ST_SHIFT:
            begin
               if (cs_rise)
                  state <= ST_IDLE;
               else if (rise_ev)
               begin
                  rx <= {si_s2, rx[7:1]};
                  bitn <= bitn + 3'h1;
                  if (bitn == 3'h7)
                  begin
                     if (last_byte)
                        state <= ST_IDLE;
                     else
                     begin
                        idx <= idx + 5'h01;
                        if (gap != 2'h0)
                        begin
                           gap_cnt <= ssbp_gap_cycles(gap) - 6'h01;
                           state <= ST_GAP;
                        end
                     end
                  end
               end
            end
            ST_GAP:
            begin
               if (cs_rise)
                  state <= ST_IDLE;
               else if (rise_ev)
               begin
                  if (gap_cnt == 6'h00)
                     state <= ST_SHIFT;
                  else
                     gap_cnt <= gap_cnt - 6'h01;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Received bytes overwrite the byte that was just sent.
   always_ff @(posedge pclk)
   begin
      if (byte_done)
         buffer[idx] <= {si_s2, rx[7:1]};
      else if (wr && is_buf && !busy)
         buffer[word[4:0]] <= pwdata[7:0];
   end

   // Software may only move the pin while idle, so a write cannot corrupt a byte.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         so_out <= 1'b0;
      else if (state == ST_SHIFT && fall_ev)
         so_out <= buffer[idx][bitn];
      else if (stat_wr && !busy)
         so_out <= pwdata[SSBP_SOL_BIT];
   end

   // ----------------------------------------------------------------
   // Status flags; a set in the same cycle beats a clear.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         {overrun_flag, wt, abort_flag} <= 3'h0;
         armed <= 3'h0;
         done_seen <= 1'b0;
      end
      else
      begin
         if (stat_rd)
            armed <= armed | prdata[SSBP_ABT_BIT +: 3];
         else
            armed <= armed & ~clr_hit;
         {overrun_flag, wt, abort_flag} <= ({overrun_flag, wt, abort_flag} & ~clr_hit) | {ovr_ev, buf_wait, abort_ev};
         if (start_wr)
            done_seen <= 1'b0;
         else if (byte_done && last_byte)
            done_seen <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_stat <= '0;
      else
         irq_stat <= (irq_stat & ~((wr && word == SSBP_IRQ_CLR_IDX) ? pwdata[SSBP_IRQ_W-1:0] : '0))
                     | {ovr_ev, buf_wait, abort_ev, (byte_done && last_byte)};
   end
   assign irq = |(irq_stat & irq_en);

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int_clock_out_a:
      assert property ((state == ST_SHIFT && !ext && int_fall && !cs_rise) |=> (!sck_out && !sck_oe_n))
      else $error("Internal clock not driven out.");
   no_gap_a:
      assert property ((byte_done && !last_byte && gap == 2'h0 && !cs_rise) |=> state == ST_SHIFT)
      else $error("Gap inserted with gap select zero.");
   gap_len_a:
      assert property ((byte_done && !last_byte && gap != 2'h0 && !cs_rise)
                       |=> (state == ST_GAP && gap_cnt == $past(ssbp_gap_cycles(gap)) - 6'h01))
      else $error("Wrong gap length loaded.");
   overrun_set_a:
      assert property (ovr_ev |=> overrun_flag)
      else $error("Overrun not flagged.");
   flag_keep_a:
      assert property ((stat_wr && !armed[2] && !ovr_ev && overrun_flag) |=> overrun_flag)
      else $error("Overrun cleared without a prior read.");
   flag_no_set_a:
      assert property ((stat_wr && pwdata[SSBP_OVERRUN_FLAG_BIT] && !overrun_flag && !ovr_ev) |=> !overrun_flag)
      else $error("Write of one set the overrun flag.");
   sol_read_a:
      assert property ((setup && !pwrite && word == SSBP_STAT_IDX) |=> prdata[SSBP_SOL_BIT] == $past(so_out))
      else $error("Extended data bit does not show the pin.");
   sol_write_a:
      assert property ((stat_wr && !busy) |=> so_out == $past(pwdata[SSBP_SOL_BIT]))
      else $error("Pin did not follow the written level.");
   start_a:
      assert property (start_wr ##1 !cs_rise |-> busy ##1 busy)
      else $error("Start did not begin a transfer.");
   abort_a:
      assert property ((state == ST_SHIFT && cs_rise) |=> (abort_flag && state == ST_IDLE))
      else $error("Chip select rise did not abort.");
   wait_a:
      assert property (buf_wait |=> wt)
      else $error("Busy buffer access not flagged.");

   xfer_done_c: cover property (byte_done && last_byte ##1 state == ST_IDLE);
   gap_seen_c: cover property (state == ST_GAP ##1 state == ST_SHIFT);
   abort_seen_c: cover property (state == ST_SHIFT && cs_rise);
   overrun_seen_c: cover property (ovr_ev);
endmodule
`default_nettype wire

// ---- sim/ssbp_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbp_partner
(
   input wire logic pclk,
   input wire logic sck_out,
   input wire logic sck_oe_n,
   input wire logic so_out,
   input wire logic cs_n_in,
   input wire logic clr,
   input wire logic [7:0] tx_byte,
   output logic sck_in,
   output logic si_in
);
   // ------------------------------------------------------------
   // Far-side serial device with its own clock for external mode.
   // ------------------------------------------------------------
   logic ext_sck = 1'h1;
   logic prev = 1'h1;
   logic seen = 1'h0;
   logic [2:0] bit_i = 3'h0;
   logic [7:0] rx_sr = 8'h00;
   logic [7:0] rx_mem [0:31];
   int rx_n = 0;
   int n_rise = 0;
   int run = 0;
   int max_high = 0;
   int max_low = 0;
   // The clock pin carries whoever drives it; the device owns it while sck_oe_n is high.
   assign sck_in = sck_oe_n ? ext_sck : sck_out;
   initial si_in = 1'h0;
   always @(posedge pclk)
   begin
      prev <= sck_in;
      run <= (sck_in === prev) ? run + 1 : 1;
      if (clr)
      begin
         seen <= 1'h0;
         max_high <= 0;
         max_low <= 0;
         rx_n <= 0;
         n_rise <= 0;
      end
      else if (prev && !sck_in && !cs_n_in)
      begin
         seen <= 1'h1;
         if (seen && run > max_high)
            max_high <= run;
      end
      else if (!prev && sck_in && !cs_n_in)
      begin
         if (run > max_low)
            max_low <= run;
         n_rise <= n_rise + 1;
         rx_sr <= {so_out, rx_sr[7:1]};
         if (n_rise[2:0] == 3'h7)
         begin
            rx_mem[rx_n] <= {so_out, rx_sr[7:1]};
            rx_n <= rx_n + 1;
         end
      end
   end
   // A deselected data line toggles so that a stale bit is never read as valid.
   always @(posedge pclk)
   begin
      if (cs_n_in)
      begin
         si_in <= ~si_in;
         bit_i <= 3'h0;
      end
      else if (prev && !sck_in)
      begin
         si_in <= tx_byte[bit_i];
         bit_i <= bit_i + 3'h1;
      end
   end
   // External clock pulses, idling high; extra pulses after completion provoke overrun.
   task automatic pulses(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge pclk);
         ext_sck <= 1'h0;
         repeat (4) @(posedge pclk);
         ext_sck <= 1'h1;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/ssbp_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module ssbp_top_bench import ssbp_pkg::*;;
   // ------------------------------------------------------------
   // Stimulus, bus tasks and checks.
   // ------------------------------------------------------------
   typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} ssbp_row_s;
   localparam logic [11:0] A_CTRL = {SSBP_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_STAT = {SSBP_STAT_IDX, 2'h0};
   localparam logic [11:0] A_LAST = {SSBP_LAST_IDX, 2'h0};
   localparam logic [11:0] A_ISTAT = {SSBP_IRQ_STAT_IDX, 2'h0};
   localparam logic [11:0] A_IEN = {SSBP_IRQ_EN_IDX, 2'h0};
   localparam logic [11:0] A_ICLR = {SSBP_IRQ_CLR_IDX, 2'h0};
   localparam logic [11:0] A_BUF = {SSBP_BUF_IDX, 2'h0};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr, clr;
   logic sck_in, sck_out, sck_oe_n, so_out, si_in, cs_n_in, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [7:0] tx_byte;
   int n_errors, n_compared, i;
   int gaps [0:3] = '{0, 8, 24, 56};
   ssbp_row_s rows [0:7] = '{
      '{1'h0, A_CTRL, 32'h0, 32'he0, 1'h0},
      '{1'h0, A_STAT, 32'h0, 32'he0, 1'h0},
      '{1'h0, A_LAST, 32'h0, 32'h1f, 1'h0},
      '{1'h0, A_ISTAT, 32'h0, 32'h0, 1'h0},
      '{1'h1, A_STAT, 32'h10, 32'hf0, 1'h1},
      '{1'h1, A_STAT, 32'h0e, 32'he0, 1'h0},
      '{1'h1, A_CTRL, 32'h1b, 32'hfb, 1'h0},
      '{1'h1, A_IEN, 32'h0f, 32'h0f, 1'h0}};
   ssbp_top #(.BUF_DEPTH(32)) ssbp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so_out(so_out), .si_in(si_in),
      .cs_n_in(cs_n_in), .irq(irq));
   ssbp_partner ssbp_partner_i (.pclk(pclk), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .so_out(so_out),
      .cs_n_in(cs_n_in), .clr(clr), .tx_byte(tx_byte), .sck_in(sck_in), .si_in(si_in));
   always #5 pclk = ~pclk;
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'h1 && k < 50);
      if (pready !== 1'h1)
      begin
         n_errors++;
         end_sim();
      end
      rdata = prdata;
      serr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      check(n, e, rdata);
   endtask
   // Polling reads status, which arms any set flag for a later clearing write.
   task automatic wait_idle();
      int k;
      for (k = 0; k < 3000; k++)
      begin
         apb(1'h0, A_STAT, 32'h0);
         if (rdata[SSBP_STF_BIT] === 1'h0)
            break;
      end
      if (k >= 3000)
      begin
         n_errors++;
         end_sim();
      end
   endtask
   task automatic xfer(input logic [7:0] ctrl, input logic [4:0] last);
      apb(1'h1, A_CTRL, {24'h0, ctrl});
      apb(1'h1, A_LAST, {27'h0, last});
      clr <= 1'h1;
      cs_n_in <= 1'h0;
      @(posedge pclk);
      clr <= 1'h0;
      apb(1'h1, A_STAT, 32'h1);
      apb(1'h0, A_STAT, 32'h0);
      check("start flag busy", 32'h1, {31'h0, rdata[SSBP_STF_BIT]});
   endtask
   initial
   begin
      pclk = 1'h0;
      presetn = 1'h0;
      {psel, penable, pwrite, clr} = 4'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      cs_n_in = 1'h1;
      tx_byte = 8'h00;
      n_errors = 0;
      n_compared = 0;
      repeat (4) @(posedge pclk);
      check("reset pins", 32'h4, {29'h0, sck_out, so_out, irq});
      presetn <= 1'h1;
      for (i = 0; i < 8; i++)
      begin
         if (rows[i].w)
            apb(1'h1, rows[i].a, rows[i].d);
         rd("register", rows[i].a, rows[i].e);
         check("serial output", {31'h0, rows[i].s}, {31'h0, so_out});
      end
      rd("unmapped data", 12'h2b0, 32'h0);
      check("unmapped error", 32'h1, {31'h0, serr});
      for (i = 0; i < 7; i++)
      begin
         xfer({5'h1c, i[2:0]}, 5'h00);
         wait_idle();
         check("clock enable", 32'h0, {31'h0, sck_oe_n});
         check("low half", (i == 0) ? 32'h80 : (32'h40 >> i), ssbp_partner_i.max_low);
      end
      for (i = 0; i < 4; i++)
      begin
         tx_byte <= 8'h3c ^ i[7:0];
         apb(1'h1, A_BUF, 32'h5a ^ i);
         apb(1'h1, A_BUF + 12'h4, 32'ha3);
         xfer({3'h7, i[1:0], 3'h3}, 5'h01);
         wait_idle();
         check("gap span", 32'h1, {31'h0, ssbp_partner_i.max_high >= gaps[i] * 16
            && ssbp_partner_i.max_high <= gaps[i] * 16 + 8});
         check("sent byte 0", 32'h5a ^ i, {24'h0, ssbp_partner_i.rx_mem[0]});
         check("sent byte 1", 32'ha3, {24'h0, ssbp_partner_i.rx_mem[1]});
         rd("received byte", A_BUF, {24'h0, 8'h3c ^ i[7:0]});
      end
      rd("done event", A_ISTAT, 32'h1);
      check("irq raised", 32'h1, {31'h0, irq});
      apb(1'h1, A_ICLR, 32'hf);
      @(posedge pclk);
      check("irq cleared", 32'h0, {31'h0, irq});
      xfer(8'he3, 5'h1f);
      rd("busy buffer read", A_BUF, 32'h0);
      cs_n_in <= 1'h1;
      // The chip select passes a two-stage synchroniser before it can abort.
      repeat (8) @(posedge pclk);
      apb(1'h1, A_STAT, 32'h0);
      rd("flags kept", A_STAT, 32'he6);
      apb(1'h1, A_STAT, 32'h0);
      rd("flags cleared", A_STAT, 32'he0);
      apb(1'h0, A_ISTAT, 32'h0);
      check("error events", 32'h6, rdata & 32'h6);
      check("irq on error", 32'h1, {31'h0, irq});
      apb(1'h1, A_IEN, 32'h0);
      @(posedge pclk);
      check("irq masked", 32'h0, {31'h0, irq});
      xfer(8'he7, 5'h00);
      check("clock input", 32'h1, {31'h0, sck_oe_n});
      ssbp_partner_i.pulses(8);
      wait_idle();
      ssbp_partner_i.pulses(1);
      repeat (6) @(posedge pclk);
      apb(1'h1, A_STAT, 32'h0);
      rd("overrun", A_STAT, 32'he8);
      apb(1'h1, A_STAT, 32'h0);
      rd("overrun cleared", A_STAT, 32'he0);
      end_sim();
   end
endmodule
`default_nettype wire
